// ### rtl/t16oc_top.v
// Purpose: output compare section of a 16-bit timer, channels A and B
// Assumes: counter, tick and TOP/BOTTOM come from logic on pclk
// Notes: APB slave with one wait state; pin direction lives elsewhere
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "t16oc_defs.vh"

module t16oc_top
(
  input  wire                   pclk,
  input  wire                   presetn,
  input  wire                   psel,
  input  wire                   penable,
  input  wire                   pwrite,
  input  wire [`T16OC_AW-1:0]   paddr,
  input  wire [31:0]            pwdata,
  output reg  [31:0]            prdata,
  output reg                    pready,
  output reg                    pslverr,
  input  wire [15:0]            counter_value,
  input  wire                   timer_tick,
  input  wire                   counter_top,
  input  wire                   counter_bottom,
  input  wire                   counter_down,
  input  wire                   counter_write,
  input  wire                   irq_ack_a,
  input  wire                   irq_ack_b,
  output reg                    irq_req_a,
  output reg                    irq_req_b,
  output reg                    match_a,
  output reg                    match_b,
  output reg                    compare_output_state_a,
  output reg                    compare_output_state_b,
  output reg  [15:0]            top_value
);

  function is_pwm;
    input [3:0] m;
    begin
      is_pwm = !((m == `T16OC_M_NORMAL) || (m == `T16OC_M_CTC_OCR) ||
                 (m == `T16OC_M_CTC_ICR) || (m == `T16OC_M_RSVD));
    end
  endfunction

  function is_fast;
    input [3:0] m;
    begin
      is_fast = (m == 4'h5) || (m == 4'h6) || (m == 4'h7) ||
                (m == 4'hE) || (m == `T16OC_M_FAST_OCR);
    end
  endfunction

  function upd_at_bottom;
    input [3:0] m;
    begin
      upd_at_bottom = (m == `T16OC_M_PFC_ICR) || (m == `T16OC_M_PFC_OCR);
    end
  endfunction

  function uses_a_top;
    input [3:0] m;
    begin
      uses_a_top = (m == `T16OC_M_CTC_OCR) || (m == `T16OC_M_PFC_OCR) ||
                   (m == `T16OC_M_PC_OCR) || (m == `T16OC_M_FAST_OCR);
    end
  endfunction

  // Non-PWM action, shared by real and forced matches
  function act_apply;
    input       cur;
    input [1:0] act;
    begin
      case (act)
        `T16OC_ACT_TOGGLE: act_apply = ~cur;
        `T16OC_ACT_CLEAR:  act_apply = 1'b0;
        `T16OC_ACT_SET:    act_apply = 1'b1;
        default:           act_apply = cur;
      endcase
    end
  endfunction

  reg  [`T16OC_CTRL_W-1:0] ctrl_r;
  reg  [7:0]               hold_hi_r;
  reg                      block_r;
  reg  [1:0]               flag_r;
  reg  [1:0]               pend_r;
  reg  [1:0]               hit_q_r;
  reg  [1:0]               state_r;
  reg  [15:0]              act_r [0:1];
  reg  [15:0]              buf_r [0:1];
  reg  [31:0]              rdata_nxt;
  reg                      rerr_nxt;

  wire [3:0] mode     = ctrl_r[`T16OC_MODE_LSB+3:`T16OC_MODE_LSB];
  wire       pwm_on   = is_pwm(mode);
  wire       access   = psel & penable;
  wire       wr_en    = access & pwrite & pready;
  wire       wr_ctrl  = wr_en & (paddr == `T16OC_CTRL_OFS);
  wire       wr_force = wr_en & (paddr == `T16OC_FORCE_OFS);
  wire       wr_flag  = wr_en & (paddr == `T16OC_FLAG_OFS);
  wire [1:0] ack_in   = {irq_ack_b, irq_ack_a};
  wire [1:0] ien      = ctrl_r[`T16OC_IEN_LSB+1:`T16OC_IEN_LSB];
  wire       upd_pt   = upd_at_bottom(mode) ? counter_bottom : counter_top;
  wire [1:0] hit;
  wire [1:0] state_nxt;

  // One wait state so that every bus output comes from a flop
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= access & ~pready;
      prdata  <= (access & ~pready & ~pwrite) ? rdata_nxt : 32'h0000_0000;
      pslverr <= access & ~pready & rerr_nxt;
    end
  end

  always @*
  begin
    rdata_nxt = 32'h0000_0000;
    rerr_nxt  = 1'b0;
    case (paddr)
      `T16OC_CTRL_OFS:
        rdata_nxt[`T16OC_CTRL_W-1:0] = ctrl_r;
      `T16OC_FORCE_OFS:
        rdata_nxt = 32'h0000_0000;
      `T16OC_FLAG_OFS:
        rdata_nxt[1:0] = flag_r;
      `T16OC_STAT_OFS:
        rdata_nxt[3:0] = {hit_q_r, state_r};
      // Reads bypass the holding byte, the value only moves on writes
      `T16OC_CMPA_HI_OFS:
        rdata_nxt[7:0] = pwm_on ? buf_r[0][15:8] : act_r[0][15:8]; // RQ12
      `T16OC_CMPA_LO_OFS:
        rdata_nxt[7:0] = pwm_on ? buf_r[0][7:0] : act_r[0][7:0]; // RQ12
      `T16OC_CMPA_HI_OFS + `T16OC_CH_STRIDE:
        rdata_nxt[7:0] = pwm_on ? buf_r[1][15:8] : act_r[1][15:8]; // RQ12
      `T16OC_CMPA_LO_OFS + `T16OC_CH_STRIDE:
        rdata_nxt[7:0] = pwm_on ? buf_r[1][7:0] : act_r[1][7:0]; // RQ12
      default:
        rerr_nxt = 1'b1;
    endcase
  end

  // Action bits are read live, so a change counts at the next match
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ctrl_r <= `T16OC_CTRL_RST;
    else if (wr_ctrl)
      ctrl_r <= pwdata[`T16OC_CTRL_W-1:0]; // RQ20
  end

  // One holding byte serves both channels; high byte must come first
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold_hi_r <= 8'h00;
    else if (wr_en & ((paddr == `T16OC_CMPA_HI_OFS) ||
                      (paddr == `T16OC_CMPA_HI_OFS + `T16OC_CH_STRIDE)))
      hold_hi_r <= pwdata[7:0]; // RQ14 RQ13
  end

  // Block lasts until the tick after the counter write
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      block_r <= 1'b0;
    else if (counter_write)
      block_r <= 1'b1; // RQ16 RQ17
    else if (timer_tick)
      block_r <= 1'b0; // RQ16 RQ23
  end

  genvar i;
  generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_ch
      wire [1:0] act_bits = ctrl_r[`T16OC_ACT_LSB+2*i+1:`T16OC_ACT_LSB+2*i];
      wire       wr_lo    = wr_en &
                            (paddr == `T16OC_CMPA_LO_OFS + i * `T16OC_CH_STRIDE);
      wire       frc      = wr_force & pwdata[i] & ~pwm_on;
      wire       pwm_tog  = (i == 0) & ((mode == `T16OC_M_FAST_OCR) ||
                            (mode == `T16OC_M_PFC_OCR) || (mode == `T16OC_M_PC_OCR));
      reg        st_nxt;

      assign hit[i] = timer_tick & ~block_r &
                      (counter_value == act_r[i]); // RQ1 RQ2 RQ16 RQ23

      // Buffer and active both follow writes outside PWM
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          buf_r[i] <= `T16OC_CMP_RST;
          act_r[i] <= `T16OC_CMP_RST;
        end
        else
        begin
          if (wr_lo)
            buf_r[i] <= {hold_hi_r, pwdata[7:0]}; // RQ14 RQ11
          if (wr_lo & ~pwm_on)
            act_r[i] <= {hold_hi_r, pwdata[7:0]}; // RQ9 RQ11
          else if (pwm_on & timer_tick & upd_pt)
            act_r[i] <= buf_r[i]; // RQ9 RQ10
        end
      end

      always @*
      begin
        st_nxt = state_r[i];
        if (frc)
          st_nxt = act_apply(state_r[i], act_bits); // RQ15
        else if (act_bits == `T16OC_ACT_NONE)
          st_nxt = state_r[i]; // RQ21
        else if (!pwm_on)
        begin
          if (hit[i])
            st_nxt = act_apply(state_r[i], act_bits); // RQ7
        end
        else if (act_bits == `T16OC_ACT_TOGGLE)
        begin
          if (hit[i] & pwm_tog)
            st_nxt = ~state_r[i]; // RQ7
        end
        else if (is_fast(mode))
        begin
          if (hit[i])
            st_nxt = (act_bits == `T16OC_ACT_SET); // RQ7
          else if (timer_tick & counter_top)
            st_nxt = (act_bits == `T16OC_ACT_CLEAR); // RQ7
        end
        else if (hit[i])
          st_nxt = (act_bits == `T16OC_ACT_SET) ^ counter_down; // RQ7
      end

      assign state_nxt[i] = st_nxt;

      // Flag follows one tick behind the match; set beats any clear
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          pend_r[i]  <= 1'b0;
          flag_r[i]  <= 1'b0;
          hit_q_r[i] <= 1'b0;
        end
        else
        begin
          hit_q_r[i] <= hit[i];
          if (timer_tick)
            pend_r[i] <= hit[i]; // RQ3 RQ23
          if (timer_tick & pend_r[i])
            flag_r[i] <= 1'b1; // RQ3
          else if (ack_in[i])
            flag_r[i] <= 1'b0; // RQ5
          else if (wr_flag & pwdata[i])
            flag_r[i] <= 1'b0; // RQ6
        end
      end
    end
  endgenerate

  // Output state survives mode changes; mode writes leave it, reset zeroes it
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_r <= 2'b00; // RQ22
    else
      state_r <= state_nxt; // RQ19
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_req_a              <= 1'b0;
      irq_req_b              <= 1'b0;
      match_a                <= 1'b0;
      match_b                <= 1'b0;
      compare_output_state_a <= 1'b0;
      compare_output_state_b <= 1'b0;
      top_value              <= 16'hFFFF;
    end
    else
    begin
      irq_req_a              <= ien[0] & flag_r[0]; // RQ4
      irq_req_b              <= ien[1] & flag_r[1]; // RQ4
      match_a                <= hit[0]; // RQ7
      match_b                <= hit[1]; // RQ7
      compare_output_state_a <= state_nxt[0];
      compare_output_state_b <= state_nxt[1];
      top_value              <= uses_a_top(mode) ? act_r[0] : 16'hFFFF; // RQ8
    end
  end

endmodule
`default_nettype wire

// ### include/t16oc_defs.vh
// Purpose: constants of the 16-bit timer output compare unit
// Assumes: APB slave, 32-bit data, byte addresses, pclk 125 MHz
// Notes: how it works is listed below
// How it works
// [RQ1] Compare full counter with each channel always
// [RQ2] Two independent channels A and B
// [RQ3] Flag set one timer tick after match
// [RQ4] Enabled flag raises channel interrupt request
// [RQ5] Interrupt service clears the flag
// [RQ6] Writing one clears flag, zero ignored
// [RQ7] Match, TOP, BOTTOM drive waveform generator
// [RQ8] Channel A value may serve as TOP
// [RQ9] Double buffer in PWM, direct otherwise
// [RQ10] Buffer copies to active at TOP/BOTTOM
// [RQ11] Software reaches buffer or active register
// [RQ12] Compare reads return both bytes directly
// [RQ13] Software writes high byte before low
// [RQ14] Low write merges held high byte
// [RQ15] Force strobe acts like match, no flag
// [RQ16] Counter write blocks next tick's matches
// [RQ17] Counter written to TOP misses TOP
// [RQ18] Software sets output before pin enable
// [RQ19] Output state kept across mode change
// [RQ20] Output action bits act immediately
// [RQ21] Zero action bits leave output unchanged
// [RQ22] Reset clears output states to zero
// [RQ23] Timing counted in timer ticks, one clock
`ifndef T16OC_DEFS_VH
`define T16OC_DEFS_VH
`define T16OC_AW          12
`define T16OC_CTRL_OFS    12'h000
`define T16OC_FORCE_OFS   12'h004
`define T16OC_FLAG_OFS    12'h008
`define T16OC_STAT_OFS    12'h00C
`define T16OC_CMPA_HI_OFS 12'h010
`define T16OC_CMPA_LO_OFS 12'h014
`define T16OC_CH_STRIDE   12'h008
`define T16OC_MODE_LSB    0
`define T16OC_ACT_LSB     4
`define T16OC_IEN_LSB     8
`define T16OC_CTRL_W      10
`define T16OC_CTRL_RST    10'h000
`define T16OC_CMP_RST     16'h0000
`define T16OC_M_NORMAL    4'h0
`define T16OC_M_CTC_OCR   4'h4
`define T16OC_M_CTC_ICR   4'hC
`define T16OC_M_RSVD      4'hD
`define T16OC_M_PFC_ICR   4'h8
`define T16OC_M_PFC_OCR   4'h9
`define T16OC_M_PC_OCR    4'hB
`define T16OC_M_FAST_OCR  4'hF
`define T16OC_ACT_NONE    2'h0
`define T16OC_ACT_TOGGLE  2'h1
`define T16OC_ACT_CLEAR   2'h2
`define T16OC_ACT_SET     2'h3
`endif

// ### dv/t16oc_sva.sv
// Purpose: port checker for the timer output compare unit
// Assumes: single pclk domain, presetn asynchronous active low
// Notes: bound to every t16oc_top instance
`timescale 1ns/10ps
`default_nettype none
`include "t16oc_defs.vh"

module t16oc_sva
(
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic [`T16OC_AW-1:0] paddr,
  input wire logic [31:0]          prdata,
  input wire logic                 pready,
  input wire logic                 pslverr,
  input wire logic                 timer_tick,
  input wire logic                 counter_write,
  input wire logic                 irq_ack_a,
  input wire logic                 irq_req_a,
  input wire logic                 match_a,
  input wire logic                 match_b,
  input wire logic                 compare_output_state_a,
  input wire logic                 compare_output_state_b,
  input wire logic [15:0]          top_value
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_pready_wait: assert property (
    psel && penable && !pready |=> pready)
    else $error("access not answered after one wait");
  a_pready_pulse: assert property (
    pready |=> !pready)
    else $error("pready held too long");
  a_rdata_idle: assert property (
    !pready |-> prdata == 32'h0000_0000)
    else $error("read data outside answer");
  a_err_unmapped: assert property (
    pready && paddr > 12'h01C |-> pslverr)
    else $error("unmapped access without error");
  a_match_tick: assert property (
    (match_a || match_b) |-> $past(timer_tick))
    else $error("match without timer tick");
  // One idle cycle in between covers the stopped timer case
  a_block_write: assert property (
    counter_write ##1 !counter_write && !timer_tick ##1 timer_tick && !counter_write
    |=> !match_a && !match_b)
    else $error("match not blocked after counter write");
  a_ack_clears: assert property (
    irq_ack_a && !timer_tick |-> ##2 !irq_req_a)
    else $error("interrupt still requested after service");
  a_reset_state: assert property (
    $rose(presetn) |-> !compare_output_state_a && !compare_output_state_b
    && top_value == 16'hFFFF)
    else $error("bad state after reset");
endmodule

bind t16oc_top t16oc_sva u_sva (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .timer_tick, .counter_write, .irq_ack_a, .irq_req_a, .match_a, .match_b,
  .compare_output_state_a, .compare_output_state_b, .top_value);
`default_nettype wire

// ### dv/t16oc_top_tb.sv
// Purpose: self-checking bench for the timer output compare unit
// Assumes: APB slave answers with one wait state
// Notes: results checked through register reads, output states at match pulses and pin samples
`timescale 1ns/10ps
`default_nettype none

module t16oc_top_tb;
  logic        pclk = 1'h0, presetn = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, seed = 32'h0000_004F;
  logic [15:0] counter_value = 16'h0000, av, vv, iv;
  logic        timer_tick = 1'h0, counter_top = 1'h0, counter_write = 1'h0;
  logic        counter_bottom = 1'h0, counter_down = 1'h0, irq_ack_a = 1'h0, irq_ack_b = 1'h0;
  wire  [31:0] prdata;
  wire  [15:0] top_value;
  wire         pready, pslverr, irq_req_a, irq_req_b, match_a, match_b;
  wire         compare_output_state_a, compare_output_state_b;
  int          mismatches = 0, tests_run = 0;
  logic [31:0] q[$], qs[$];

  t16oc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .counter_value, .timer_tick, .counter_top, .counter_bottom,
    .counter_down, .counter_write, .irq_ack_a, .irq_ack_b, .irq_req_a, .irq_req_b,
    .match_a, .match_b, .compare_output_state_a, .compare_output_state_b, .top_value);

  always #4 pclk = ~pclk;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    q.push_back(e);
    apb(1'h0, a, 32'h0000_0000);
  endtask

  // High byte first: the held byte is shared by both channels
  task automatic wcmp(input logic [11:0] a, input logic [15:0] v);
    apb(1'h1, a, {24'h00_0000, v[15:8]});
    apb(1'h1, a + 12'h004, {24'h00_0000, v[7:0]});
  endtask

  task automatic tk(input logic [15:0] c, input logic t);
    @(posedge pclk);
    counter_value <= c;
    counter_top <= t;
    timer_tick <= 1'h1;
    @(posedge pclk);
    timer_tick <= 1'h0;
    counter_top <= 1'h0;
  endtask

  task automatic chk(input logic [31:0] got);
    logic [31:0] e;
    e = (q.size() > 0) ? q.pop_front() : 32'hDEAD_BEEF;
    tests_run++;
    if (got !== e)
    begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, e);
      mismatches++;
    end
  endtask

  // Output states as shown in the cycle of each match pulse
  task automatic chk_st(input logic [31:0] got);
    logic [31:0] e;
    e = (qs.size() > 0) ? qs.pop_front() : 32'hDEAD_BEEF;
    tests_run++;
    if (got !== e)
    begin
      $display("[FAIL] t=%0t state got=%h exp=%h", $time, got, e);
      mismatches++;
    end
  endtask

  // Level outputs are sampled away from the launching edge
  task automatic chk_pin(input logic [31:0] got, input logic [31:0] e);
    tests_run++;
    if (got !== e)
    begin
      $display("[FAIL] t=%0t pin got=%h exp=%h", $time, got, e);
      mismatches++;
    end
  endtask

  always @(posedge pclk)
    if (psel && penable && pready === 1'h1 && !pwrite)
      chk(prdata);

  // An unexpected match pops an empty queue and fails
  always @(posedge pclk)
    if (match_a === 1'h1 || match_b === 1'h1)
      chk_st({30'h0000_0000, compare_output_state_b, compare_output_state_a});

  // Whole sequence needs under two hundred cycles
  initial
  begin
    #20000;
    mismatches++;
    print_verdict();
  end

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    seed = xs(seed);
    av = seed[15:0];
    vv = av ^ 16'h00FF;
    iv = av ^ 16'h4000;
    rd(12'h00C, 32'h0000_0000);
    rd(12'h100, 32'h0000_0000);
    wcmp(12'h010, av);
    wcmp(12'h018, av ^ 16'h8000);
    rd(12'h010, {24'h00_0000, av[15:8]});
    rd(12'h014, {24'h00_0000, av[7:0]});
    rd(12'h018, {24'h00_0000, av[15:8] ^ 8'h80});
    apb(1'h1, 12'h000, 32'h0000_0110);
    qs.push_back(32'h0000_0001);
    tk(av, 1'h0);
    rd(12'h008, 32'h0000_0000);
    tk(iv, 1'h0);
    rd(12'h008, 32'h0000_0001);
    @(negedge pclk) chk_pin({31'h0000_0000, irq_req_a}, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0001);
    apb(1'h1, 12'h008, 32'h0000_0000);
    rd(12'h008, 32'h0000_0001);
    apb(1'h1, 12'h008, 32'h0000_0001);
    rd(12'h008, 32'h0000_0000);
    @(negedge pclk) chk_pin({31'h0000_0000, irq_req_a}, 32'h0000_0000);
    qs.push_back(32'h0000_0000);
    tk(av, 1'h0);
    tk(iv, 1'h0);
    @(posedge pclk) irq_ack_a <= 1'h1;
    @(posedge pclk) irq_ack_a <= 1'h0;
    rd(12'h008, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0000);
    @(posedge pclk) counter_write <= 1'h1;
    @(posedge pclk) counter_write <= 1'h0;
    tk(av, 1'h0);
    tk(iv, 1'h0);
    rd(12'h008, 32'h0000_0000);
    apb(1'h1, 12'h000, 32'h0000_01D0);
    apb(1'h1, 12'h004, 32'h0000_0002);
    rd(12'h00C, 32'h0000_0002);
    rd(12'h008, 32'h0000_0000);
    apb(1'h1, 12'h000, 32'h0000_000F);
    rd(12'h00C, 32'h0000_0002);
    wcmp(12'h010, vv);
    rd(12'h014, {24'h00_0000, vv[7:0]});
    tk(vv, 1'h0);
    tk(iv, 1'h0);
    rd(12'h008, 32'h0000_0000);
    tk(iv, 1'h1);
    qs.push_back(32'h0000_0002);
    tk(vv, 1'h0);
    tk(iv, 1'h0);
    rd(12'h008, 32'h0000_0001);
    rd(12'h00C, 32'h0000_0002);
    @(negedge pclk) chk_pin({16'h0000, top_value}, {16'h0000, vv});
    @(posedge pclk);
    print_verdict();
  end
endmodule
`default_nettype wire
